/* File: logic/hbcr_consts.svh */
// Constants of the host byte command responder: command codes, answers, pin codes, timing.
// Assumes one 125 MHz clock and bytes handed over by a USB byte bridge.
//
// Notes on behaviour
// (R1) 0xD9 samples temperature monitor input 3 raw.
// (R2) Raw replies: 12 bits right-justified, MSB first.
// (R3) 0xDA samples converter 0 from output converter 0.
// (R4) 0xDB samples converter 1 from output converter 1.
// (R5) Subsystem pin codes 0x16-0x31 read decimally.
// (R6) Bit 8 (pin code 24) drives the lamp active low.
// (R7) Codes 01-03, 05-07 are fabric input pins.
// (R8) Codes 16-20, 22, 24, 68 are fabric outputs.
// (R9) Codes 21 and 23 are readable fabric inputs.
// (R10) Faulty commands answer one byte 0xEn.
// (R11) Register read index above 5 answers 0xE0.
// (R12) Unknown command byte answers 0xE1.
// (R13) Clear with bad pin answers 0xE2.
// (R14) Set with bad pin answers 0xE3.
// (R15) Read with bad pin answers 0xE4.
// (R16) Bad shared-memory access flags 0xE5/E6/E7 by size.
// (R17) Subsystem silent two seconds answers 0xE8.
// (R18) Subsystem itself answers 0xE9 for unknown commands.
// (R19) Pin read answers 0x00 low, 0x01 high.
// (R20) Good clear or set echoes the pin code.
// (R21) Ping answers 0xC3 running, 0xE8 stopped.
// (R22) Argument byte follows command; one command at once.
// (R23) Host reads whole reply before next command.
`ifndef HBCR_CONSTS_SVH
`define HBCR_CONSTS_SVH

`define HBCR_CMD_VERSION 8'h10
`define HBCR_CMD_LOOP 8'h20
`define HBCR_CMD_LOOP_INV 8'h21
`define HBCR_CMD_FAB_READ 8'h30
`define HBCR_CMD_FAB_CLR 8'h40
`define HBCR_CMD_FAB_SET 8'h41
`define HBCR_CMD_PING 8'h70
`define HBCR_CMD_STATUS_HI 4'h8
`define HBCR_CMD_GPIO_READ 8'h90
`define HBCR_CMD_GPIO_CLR 8'ha0
`define HBCR_CMD_GPIO_SET 8'ha1
`define HBCR_CMD_RAW_TEMP3 8'hd9
`define HBCR_CMD_RAW_LOOP0 8'hda
`define HBCR_CMD_RAW_LOOP1 8'hdb

`define HBCR_ADC_CH_TEMP3 2'h0
`define HBCR_ADC_CH_LOOP0 2'h1
`define HBCR_ADC_CH_LOOP1 2'h2

`define HBCR_ERR_REG 8'he0
`define HBCR_ERR_CMD 8'he1
`define HBCR_ERR_CLR 8'he2
`define HBCR_ERR_SET 8'he3
`define HBCR_ERR_READ 8'he4
`define HBCR_ERR_SHM8 8'he5
`define HBCR_ERR_SHM16 8'he6
`define HBCR_ERR_SHM32 8'he7
`define HBCR_ERR_TIMEOUT 8'he8
`define HBCR_PING_OK 8'hc3
`define HBCR_PIN_LOW 8'h00
`define HBCR_PIN_HIGH 8'h01

`define HBCR_VERSION_MAX 8'h05
`define HBCR_GPIO_BASE 5'h10
`define HBCR_GPIO_LAMP 4'h8
`define HBCR_GPIO_RESET 16'h0100

`define HBCR_TIMEOUT_MS 64'd2000
`define HBCR_CLK_KHZ 64'd125000

`endif

/* File: logic/hbcr_pkg.sv */
// Types shared by the host byte command responder modules.
// Assumes the constants header is included by the modules that use it.
package hbcr_pkg;

  // ==========================================================================
  // Command engine states.
  typedef enum logic [2:0] {HBCR_IDLE, HBCR_ARG, HBCR_ADC, HBCR_PSS} hbcr_state_t;

  typedef logic [7:0] hbcr_byte_t;

endpackage : hbcr_pkg

/* File: logic/hbcr_reply_if.sv */
// Carrier between the command engine and the reply sender.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface hbcr_reply_if;
  logic load;
  logic two;
  logic [15:0] word;
  logic busy;

  modport src (output load, output two, output word, input busy);
  modport snk (input load, input two, input word, output busy);
endinterface : hbcr_reply_if
`default_nettype wire

/* File: logic/hbcr_reply_tx.sv */
// Reply sender: puts one or two reply bytes on the byte bridge, high byte first.
// Assumes the bridge takes a byte when valid and ready are both high.
`timescale 1ns/1ps
`default_nettype none
module hbcr_reply_tx
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  hbcr_reply_if.snk rply,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);
  import hbcr_pkg::*;

  logic busy_reg;
  logic second_reg;
  logic [7:0] low_reg;
  logic [7:0] data_reg;
  logic valid_reg;

  wire start = rply.load && !busy_reg;
  wire taken = valid_reg && tx_ready_i;

  assign rply.busy = busy_reg;
  assign tx_data_o = data_reg;
  assign tx_valid_o = valid_reg;

  // ==========================================================================
  // Byte sequencing.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      busy_reg <= 1'b0;
      second_reg <= 1'b0;
      low_reg <= 8'h00;
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
    end
    else if (start)
    begin
      busy_reg <= 1'b1;
      valid_reg <= 1'b1;
      second_reg <= rply.two;
      low_reg <= rply.word[7:0];
      data_reg <= rply.two ? rply.word[15:8] : rply.word[7:0]; // R2
    end
    else if (taken)
    begin
      if (second_reg)
      begin
        data_reg <= low_reg; // R2
        second_reg <= 1'b0;
      end
      else
      begin
        valid_reg <= 1'b0;
        busy_reg <= 1'b0;
      end
    end
  end

endmodule : hbcr_reply_tx
`default_nettype wire

/* File: logic/hbcr_top.sv */
// Host byte command responder: decodes host command bytes and answers them.
// Assumes bytes arrive from a USB byte bridge with valid/ready, and a processor
// subsystem and converter that answer requests with one-cycle strobes.
`include "hbcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hbcr_top
#(
  parameter longint TIMEOUT_CYCLES = `HBCR_TIMEOUT_MS * `HBCR_CLK_KHZ,
  parameter logic [47:0] VERSION_BYTES = 48'h050403020100 // Arbitrary value.
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire hbcr_pkg::hbcr_byte_t rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output hbcr_pkg::hbcr_byte_t tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic adc_req_o,
  output logic [1:0] adc_chan_o,
  input wire logic adc_done_i,
  input wire logic [11:0] adc_data_i,
  input wire logic [7:0] fab_in_i,
  output logic [7:0] fab_out_o,
  input wire logic [15:0] gpio_in_i,
  output logic [15:0] gpio_o,
  output logic pss_req_o,
  output hbcr_pkg::hbcr_byte_t pss_cmd_o,
  input wire logic pss_ack_i,
  input wire hbcr_pkg::hbcr_byte_t pss_data_i,
  input wire logic pss_running_i,
  input wire logic shm_err_i,
  input wire logic [1:0] shm_err_size_i
);
  import hbcr_pkg::*;

  // ==========================================================================
  // Pin code decoding.
  function automatic logic [4:0] gpio_decode(input logic [7:0] code);
    logic [4:0] val;
    val = 5'(code[7:4] * 4'd10 + code[3:0]);
    if (code[3:0] <= 4'h9 && code[7:4] >= 4'h1 && code[7:4] <= 4'h3 && val >= `HBCR_GPIO_BASE)
      gpio_decode = {1'b1, 4'(val - `HBCR_GPIO_BASE)}; // R5
    else
      gpio_decode = 5'h00;
  endfunction : gpio_decode

  function automatic logic [3:0] fab_in_decode(input logic [7:0] code);
    case (code)
      8'h01: fab_in_decode = 4'h8; // R7
      8'h02: fab_in_decode = 4'h9;
      8'h03: fab_in_decode = 4'ha;
      8'h05: fab_in_decode = 4'hb;
      8'h06: fab_in_decode = 4'hc;
      8'h07: fab_in_decode = 4'hd;
      8'h21: fab_in_decode = 4'he; // R9
      8'h23: fab_in_decode = 4'hf;
      default: fab_in_decode = 4'h0;
    endcase
  endfunction : fab_in_decode

  function automatic logic [3:0] fab_out_decode(input logic [7:0] code);
    case (code)
      8'h16: fab_out_decode = 4'h8; // R8
      8'h17: fab_out_decode = 4'h9;
      8'h18: fab_out_decode = 4'ha;
      8'h19: fab_out_decode = 4'hb;
      8'h20: fab_out_decode = 4'hc;
      8'h22: fab_out_decode = 4'hd;
      8'h24: fab_out_decode = 4'he;
      8'h68: fab_out_decode = 4'hf;
      default: fab_out_decode = 4'h0;
    endcase
  endfunction : fab_out_decode

  // ==========================================================================
  // State.
  localparam longint TIMEOUT_LAST = TIMEOUT_CYCLES - 1;

  hbcr_state_t state_reg, state_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [31:0] timer_reg, timer_next;
  logic rx_ready_reg, rx_ready_next;
  logic [7:0] fab_out_reg, fab_out_next;
  logic [15:0] gpio_reg, gpio_next;
  logic adc_req_reg, adc_req_next;
  logic [1:0] adc_chan_reg, adc_chan_next;
  logic pss_req_reg, pss_req_next;
  logic [7:0] pss_cmd_reg, pss_cmd_next;
  logic [2:0] shm_reg, shm_next;
  logic ld_reg, ld_next;
  logic two_reg, two_next;
  logic [15:0] word_reg, word_next;

  hbcr_reply_if rply ();

  assign rply.load = ld_reg;
  assign rply.two = two_reg;
  assign rply.word = word_reg;

  // ==========================================================================
  // Argument decoding.
  wire rx_take = rx_valid_i && rx_ready_reg;
  wire [7:0] arg = rx_data_i;
  wire [4:0] gpio_sel = gpio_decode(arg);
  wire [3:0] fin_sel = fab_in_decode(arg);
  wire [3:0] fout_sel = fab_out_decode(arg);
  wire [2:0] ver_idx = arg[2:0];
  wire ver_ok = arg <= `HBCR_VERSION_MAX;
  wire [7:0] ver_byte = VERSION_BYTES[{ver_idx, 3'b000} +: 8];
  wire [15:0] fab_in_all = {fab_in_i, 8'h00};
  wire [7:0] pin_lvl_fab = fab_in_all[fin_sel] ? `HBCR_PIN_HIGH : `HBCR_PIN_LOW; // R19
  wire [7:0] pin_lvl_gpio = gpio_in_i[gpio_sel[3:0]] ? `HBCR_PIN_HIGH : `HBCR_PIN_LOW; // R19
  wire needs_arg = rx_data_i == `HBCR_CMD_VERSION || rx_data_i == `HBCR_CMD_LOOP
                || rx_data_i == `HBCR_CMD_LOOP_INV || rx_data_i == `HBCR_CMD_FAB_READ
                || rx_data_i == `HBCR_CMD_FAB_CLR || rx_data_i == `HBCR_CMD_FAB_SET
                || rx_data_i == `HBCR_CMD_GPIO_READ || rx_data_i == `HBCR_CMD_GPIO_CLR
                || rx_data_i == `HBCR_CMD_GPIO_SET; // R22
  wire is_raw = rx_data_i == `HBCR_CMD_RAW_TEMP3 || rx_data_i == `HBCR_CMD_RAW_LOOP0
             || rx_data_i == `HBCR_CMD_RAW_LOOP1;
  wire [1:0] raw_chan = rx_data_i == `HBCR_CMD_RAW_TEMP3 ? `HBCR_ADC_CH_TEMP3 : // R1
                        rx_data_i == `HBCR_CMD_RAW_LOOP0 ? `HBCR_ADC_CH_LOOP0 : // R3
                        `HBCR_ADC_CH_LOOP1; // R4
  wire [2:0] shm_set = shm_err_i ? (3'h1 << shm_err_size_i) : 3'h0;
  wire [7:0] shm_code = shm_reg[0] ? `HBCR_ERR_SHM8 :
                        shm_reg[1] ? `HBCR_ERR_SHM16 : `HBCR_ERR_SHM32; // R16
  wire [2:0] shm_clr = shm_reg[0] ? 3'h1 : shm_reg[1] ? 3'h2 : 3'h4;
  wire reply_free = !ld_reg && !rply.busy;

  // ==========================================================================
  // Command engine.
  always_comb
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    timer_next = timer_reg;
    fab_out_next = fab_out_reg;
    gpio_next = gpio_reg;
    adc_req_next = 1'b0;
    adc_chan_next = adc_chan_reg;
    pss_req_next = 1'b0;
    pss_cmd_next = pss_cmd_reg;
    shm_next = shm_reg;
    ld_next = 1'b0;
    two_next = 1'b0;
    word_next = word_reg;
    case (state_reg)
      HBCR_IDLE:
      begin
        if (shm_reg != 3'h0 && reply_free)
        begin
          ld_next = 1'b1;
          word_next = {8'h00, shm_code}; // R16
          shm_next = shm_reg & ~shm_clr;
        end
        else if (rx_take)
        begin
          cmd_next = rx_data_i;
          if (needs_arg)
            state_next = HBCR_ARG; // R22
          else if (rx_data_i == `HBCR_CMD_PING)
          begin
            ld_next = 1'b1;
            word_next = {8'h00, pss_running_i ? `HBCR_PING_OK : `HBCR_ERR_TIMEOUT}; // R21
          end
          else if (is_raw)
          begin
            adc_req_next = 1'b1;
            adc_chan_next = raw_chan;
            state_next = HBCR_ADC;
          end
          else if (rx_data_i[7:4] == `HBCR_CMD_STATUS_HI)
          begin
            pss_req_next = 1'b1;
            pss_cmd_next = rx_data_i;
            timer_next = 32'h0;
            state_next = HBCR_PSS;
          end
          else
          begin
            ld_next = 1'b1;
            word_next = {8'h00, `HBCR_ERR_CMD}; // R12
          end
        end
      end
      HBCR_ARG:
      begin
        if (rx_take)
        begin
          ld_next = 1'b1;
          state_next = HBCR_IDLE;
          word_next = {8'h00, arg}; // R20
          case (cmd_reg)
            `HBCR_CMD_VERSION:
              word_next = {8'h00, ver_ok ? ver_byte : `HBCR_ERR_REG}; // R11
            `HBCR_CMD_LOOP_INV:
              word_next = {8'h00, ~arg};
            `HBCR_CMD_FAB_READ:
              word_next = {8'h00, fin_sel[3] ? pin_lvl_fab : `HBCR_ERR_READ}; // R15
            `HBCR_CMD_FAB_CLR:
              if (fout_sel[3])
                fab_out_next[fout_sel[2:0]] = 1'b0; // R8
              else
                word_next = {8'h00, `HBCR_ERR_CLR}; // R13
            `HBCR_CMD_FAB_SET:
              if (fout_sel[3])
                fab_out_next[fout_sel[2:0]] = 1'b1; // R8
              else
                word_next = {8'h00, `HBCR_ERR_SET}; // R14
            `HBCR_CMD_GPIO_READ:
              word_next = {8'h00, gpio_sel[4] ? pin_lvl_gpio : `HBCR_ERR_READ}; // R15
            `HBCR_CMD_GPIO_CLR:
              if (gpio_sel[4])
                gpio_next[gpio_sel[3:0]] = 1'b0; // R6
              else
                word_next = {8'h00, `HBCR_ERR_CLR}; // R13
            `HBCR_CMD_GPIO_SET:
              if (gpio_sel[4])
                gpio_next[gpio_sel[3:0]] = 1'b1; // R5
              else
                word_next = {8'h00, `HBCR_ERR_SET}; // R14
            default:
              word_next = {8'h00, arg};
          endcase
        end
      end
      HBCR_ADC:
      begin
        if (adc_done_i)
        begin
          ld_next = 1'b1;
          two_next = 1'b1;
          word_next = {4'h0, adc_data_i}; // R2
          state_next = HBCR_IDLE;
        end
      end
      HBCR_PSS:
      begin
        timer_next = timer_reg + 32'h1;
        if (pss_ack_i)
        begin
          ld_next = 1'b1;
          word_next = {8'h00, pss_data_i}; // R18
          state_next = HBCR_IDLE;
        end
        else if (64'(timer_reg) >= 64'(TIMEOUT_LAST))
        begin
          ld_next = 1'b1;
          word_next = {8'h00, `HBCR_ERR_TIMEOUT}; // R17
          state_next = HBCR_IDLE;
        end
      end
      default:
        state_next = HBCR_IDLE;
    endcase
    shm_next = shm_next | shm_set;
  end

  // R10 R22 R23
  assign rx_ready_next = !ld_next && reply_free
                      && (state_next == HBCR_ARG || (state_next == HBCR_IDLE && shm_next == 3'h0));

  // ==========================================================================
  // Registers.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= HBCR_IDLE;
      cmd_reg <= 8'h00;
      timer_reg <= 32'h0;
      rx_ready_reg <= 1'b0;
      fab_out_reg <= 8'h00;
      gpio_reg <= `HBCR_GPIO_RESET;
      adc_req_reg <= 1'b0;
      adc_chan_reg <= 2'h0;
      pss_req_reg <= 1'b0;
      pss_cmd_reg <= 8'h00;
      shm_reg <= 3'h0;
      ld_reg <= 1'b0;
      two_reg <= 1'b0;
      word_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      timer_reg <= timer_next;
      rx_ready_reg <= rx_ready_next;
      fab_out_reg <= fab_out_next;
      gpio_reg <= gpio_next;
      adc_req_reg <= adc_req_next;
      adc_chan_reg <= adc_chan_next;
      pss_req_reg <= pss_req_next;
      pss_cmd_reg <= pss_cmd_next;
      shm_reg <= shm_next;
      ld_reg <= ld_next;
      two_reg <= two_next;
      word_reg <= word_next;
    end
  end

  assign rx_ready_o = rx_ready_reg;
  assign fab_out_o = fab_out_reg;
  assign gpio_o = gpio_reg;
  assign adc_req_o = adc_req_reg;
  assign adc_chan_o = adc_chan_reg;
  assign pss_req_o = pss_req_reg;
  assign pss_cmd_o = pss_cmd_reg;

  // ==========================================================================
  // Reply sender.
  hbcr_reply_tx u_reply
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rply(rply),
    .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i)
  );

endmodule : hbcr_top
`default_nettype wire

/* File: testbench/hbcr_props.sv */
// Assertions on the ports of the host byte command responder.
// Assumes the design top is hbcr_top, bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module hbcr_props
#(
  parameter longint TIMEOUT_CYCLES = 50
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire hbcr_pkg::hbcr_byte_t rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire hbcr_pkg::hbcr_byte_t tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic adc_req_o,
  input wire logic [1:0] adc_chan_o,
  input wire logic adc_done_i,
  input wire logic [11:0] adc_data_i,
  input wire logic [7:0] fab_out_o,
  input wire logic [15:0] gpio_o,
  input wire logic pss_req_o,
  input wire logic pss_ack_i,
  input wire hbcr_pkg::hbcr_byte_t pss_data_i
);
  import hbcr_pkg::*;
  logic [3:0] adc_hi_reg;
  hbcr_byte_t ack_reg;
  longint wait_reg;
  logic arg_wait_reg;
  wire arg_cmd = rx_data_i inside {8'h10, 8'h20, 8'h21, 8'h30, 8'h40, 8'h41, 8'h90, 8'ha0, 8'ha1};
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================================
  // Helper state: captured answers and the subsystem wait count.
  always_ff @(posedge clk_i)
  begin
    if (adc_done_i)
      adc_hi_reg <= adc_data_i[11:8];
    if (pss_ack_i)
      ack_reg <= pss_data_i;
    if (sys_rst_i || pss_ack_i || tx_valid_o)
      wait_reg <= '0;
    else if (pss_req_o || wait_reg != 0)
      wait_reg <= wait_reg + 64'd1;
    if (sys_rst_i)
      arg_wait_reg <= 1'b0;
    else if (rx_valid_i && rx_ready_o)
      arg_wait_reg <= !arg_wait_reg && arg_cmd;
  end
  // ==========================================================================
  // Properties.
  AST_RST_STATE: assert property (disable iff (1'b0) sys_rst_i |=> !rx_ready_o && !tx_valid_o
    && !adc_req_o && fab_out_o == 8'h00 && gpio_o == 16'h0100)
    else $error("outputs not at reset state");
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_data_o)) else $error("reply byte dropped or changed while stalled");
  AST_TX_BLOCKS_RX: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("byte taken while a reply is pending");
  AST_TAKE_ONE: assert property (rx_valid_i && rx_ready_o && (arg_wait_reg || !arg_cmd)
    |=> !rx_ready_o) else $error("ready not lowered after a byte was taken");
  AST_ADC_PULSE: assert property (adc_req_o |=> !adc_req_o)
    else $error("conversion request longer than one cycle");
  AST_ADC_REPLY: assert property (adc_done_i |-> ##2 tx_valid_o
    && tx_data_o == {4'h0, adc_hi_reg}) else $error("raw high byte wrong or late");
  AST_ADC_CHAN: assert property (rx_valid_i && rx_ready_o && rx_data_i == 8'hd9
    && !arg_wait_reg |-> ##[1:4] adc_req_o && adc_chan_o == 2'h0)
    else $error("temperature channel not sampled");
  AST_PSS_PULSE: assert property (pss_req_o |=> !pss_req_o)
    else $error("subsystem request longer than one cycle");
  AST_PSS_PASS: assert property (pss_ack_i |-> ##2 tx_valid_o && tx_data_o == ack_reg)
    else $error("subsystem answer not passed on");
  AST_PSS_BOUND: assert property (wait_reg <= TIMEOUT_CYCLES + 8)
    else $error("subsystem wait not ended by timeout");
endmodule : hbcr_props
bind hbcr_top hbcr_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) hbcr_props_i (.clk_i, .sys_rst_i,
  .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .adc_req_o,
  .adc_chan_o, .adc_done_i, .adc_data_i, .fab_out_o, .gpio_o, .pss_req_o, .pss_ack_i,
  .pss_data_i);
`default_nettype wire

/* File: testbench/hbcr_peer.sv */
// Model of the converter and processor subsystem beside the responder.
// Assumes requests are one-cycle pulses; answers come after a set delay.
`timescale 1ns/1ps
`default_nettype none
module hbcr_peer
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic adc_req_i,
  input wire logic [1:0] adc_chan_i,
  output logic adc_done_o,
  output logic [11:0] adc_data_o,
  input wire logic pss_req_i,
  output logic pss_ack_o,
  output hbcr_pkg::hbcr_byte_t pss_data_o,
  input wire logic [11:0] sample_i,
  input wire hbcr_pkg::hbcr_byte_t answer_i,
  input wire logic silent_i,
  input wire logic [3:0] delay_i,
  output logic [1:0] chan_o
);
  import hbcr_pkg::*;
  logic [4:0] adc_cnt_reg;
  logic [4:0] pss_cnt_reg;
  // ==========================================================================
  // Answers after the delay; data lines toggle outside an answer.
  always_ff @(posedge clk_i)
  begin
    adc_cnt_reg <= sys_rst_i ? 5'h0 : adc_req_i ? {1'b0, delay_i} + 5'h1
      : adc_cnt_reg - {4'h0, adc_cnt_reg != 5'h0};
    pss_cnt_reg <= sys_rst_i ? 5'h0 : pss_req_i ? {1'b0, delay_i} + 5'h1
      : pss_cnt_reg - {4'h0, pss_cnt_reg != 5'h0};
    adc_done_o <= adc_cnt_reg == 5'h1;
    adc_data_o <= sys_rst_i ? 12'h0 : (adc_cnt_reg == 5'h1) ? sample_i : ~adc_data_o;
    pss_ack_o <= pss_cnt_reg == 5'h1 && !silent_i;
    pss_data_o <= sys_rst_i ? 8'h0 : (pss_cnt_reg == 5'h1) ? answer_i : ~pss_data_o;
    if (adc_req_i)
      chan_o <= adc_chan_i;
  end
endmodule : hbcr_peer
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench of the host byte command responder.
// Assumes the bench acts as host; the peer model answers requests.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hbcr_pkg::*;
  logic clk_i, sys_rst_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic adc_req_o, adc_done_i, pss_req_o, pss_ack_i, pss_running_i, shm_err_i, silent;
  hbcr_byte_t rx_data_i, tx_data_o, pss_cmd_o, pss_data_i, answer, code;
  logic [1:0] adc_chan_o, shm_err_size_i, chan;
  logic [11:0] adc_data_i, sample;
  logic [7:0] fab_in_i, fab_out_o;
  logic [15:0] gpio_in_i, gpio_o;
  logic [3:0] delay;
  hbcr_byte_t exp_q[$];
  hbcr_byte_t fin[8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h21, 8'h23};
  hbcr_byte_t fout[8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h20, 8'h22, 8'h24, 8'h68};
  // Entries: command, argument, reply, argument present.
  logic [31:0] tbl[12] = '{32'h1006e001, 32'h1003c301, 32'h5500e100, 32'hff00e100,
    32'h4004e201, 32'h4121e301, 32'h3016e401, 32'h901ae401, 32'ha032e201,
    32'ha115e301, 32'h205a5a01, 32'h215aa501};
  int failures = 0;
  int n_checks = 0;

  hbcr_top #(.TIMEOUT_CYCLES(50), .VERSION_BYTES(48'ha5b4c3d2e1f0)) hbcr_top_i (.clk_i,
    .sys_rst_i, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i,
    .adc_req_o, .adc_chan_o, .adc_done_i, .adc_data_i, .fab_in_i, .fab_out_o, .gpio_in_i,
    .gpio_o, .pss_req_o, .pss_cmd_o, .pss_ack_i, .pss_data_i, .pss_running_i, .shm_err_i,
    .shm_err_size_i);
  hbcr_peer hbcr_peer_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .adc_req_i(adc_req_o),
    .adc_chan_i(adc_chan_o), .adc_done_o(adc_done_i), .adc_data_o(adc_data_i),
    .pss_req_i(pss_req_o), .pss_ack_o(pss_ack_i), .pss_data_o(pss_data_i),
    .sample_i(sample), .answer_i(answer), .silent_i(silent), .delay_i(delay), .chan_o(chan));

  // ==========================================================================
  // Helpers.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic send(input hbcr_byte_t b);
    int k;
    @(negedge clk_i);
    rx_data_i = b;
    rx_valid_i = 1'b1;
    k = 0;
    @(posedge clk_i);
    while (rx_ready_o !== 1'b1 && k < 5000)
    begin
      k++;
      @(posedge clk_i);
    end
    if (rx_ready_o !== 1'b1)
      failures++;
    @(negedge clk_i);
    rx_valid_i = 1'b0;
    rx_data_i = ~b;
  endtask : send

  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 5000)
    begin
      k++;
      @(negedge clk_i);
    end
    if (exp_q.size() != 0)
      failures++;
  endtask : drain

  task automatic op(input hbcr_byte_t c, input hbcr_byte_t a, input bit two, input hbcr_byte_t e);
    exp_q.push_back(e);
    send(c);
    if (two)
      send(a);
    drain();
  endtask : op

  // ==========================================================================
  // Clock, host stalls, reply monitor and watchdog.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
    tx_ready_i = $urandom_range(3) != 0;
  always @(posedge clk_i)
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected reply", 16'h0, {8'h1, tx_data_o});
      else
        chk("reply byte", {8'h0, exp_q.pop_front()}, {8'h0, tx_data_o});
    end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    final_report();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    void'($urandom(32'h677c));
    {rx_valid_i, pss_running_i, shm_err_i, silent} = '0;
    {rx_data_i, answer, fab_in_i, gpio_in_i, sample, delay, shm_err_size_i} = '0;
    sys_rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("gpio reset", 16'h0100, gpio_o);
    for (int i = 0; i < 3; i++)
    begin
      sample = 12'($urandom);
      delay = 4'($urandom);
      exp_q.push_back({4'h0, sample[11:8]});
      op(8'hd9 + 8'(i), 8'h0, 1'b0, sample[7:0]);
      chk("converter channel", 16'(i), {14'h0, chan});
    end
    for (int n = 16; n < 32; n++)
    begin
      code = {4'(n / 10), 4'(n % 10)};
      op(8'ha1, code, 1'b1, code);
      chk("gpio set", 16'h1, 16'(gpio_o[n - 16]));
      gpio_in_i = 16'($urandom);
      op(8'h90, code, 1'b1, {7'h0, gpio_in_i[n - 16]});
      op(8'ha0, code, 1'b1, code);
      chk("gpio clear", 16'h0, 16'(gpio_o[n - 16]));
    end
    for (int n = 0; n < 8; n++)
    begin
      fab_in_i = 8'($urandom);
      op(8'h30, fin[n], 1'b1, {7'h0, fab_in_i[n]});
      op(8'h41, fout[n], 1'b1, fout[n]);
      chk("fabric set", 16'h1, 16'(fab_out_o[n]));
      op(8'h40, fout[n], 1'b1, fout[n]);
      chk("fabric clear", 16'h0, 16'(fab_out_o[n]));
    end
    foreach (tbl[i])
      op(tbl[i][31:24], tbl[i][23:16], tbl[i][0], tbl[i][15:8]);
    for (int n = 0; n < 2; n++)
    begin
      pss_running_i = n[0];
      op(8'h70, 8'h0, 1'b0, n[0] ? 8'hc3 : 8'he8);
      answer = n[0] ? 8'he9 : 8'($urandom);
      delay = 4'($urandom);
      op(8'h80 + 8'(n), 8'h0, 1'b0, answer);
      chk("subsystem command", {8'h0, 8'h80 + 8'(n)}, {8'h0, pss_cmd_o});
    end
    silent = 1'b1;
    op(8'h8a, 8'h0, 1'b0, 8'he8);
    chk("subsystem command", 16'h008a, {8'h0, pss_cmd_o});
    silent = 1'b0;
    for (int n = 0; n < 3; n++)
    begin
      exp_q.push_back(8'he5 + 8'(n));
      shm_err_size_i = 2'(n);
      shm_err_i = 1'b1;
      @(negedge clk_i);
      shm_err_i = 1'b0;
      drain();
    end
    repeat (4) @(negedge clk_i);
    chk("replies left", 16'h0, 16'(exp_q.size()));
    final_report();
  end
endmodule : testbench
`default_nettype wire
